// ---- pdl_defs.vh ----
// Constants for the power-down and low-voltage control block
// How it works
// - Sleep instruction enters deep idle when depth bit is 1, else light idle
// - Warmup select 1 gives 16 oscillator cycles, 0 gives 256 cycles
// - Light idle halts the core; oscillator, interrupts, timers, tone keep running
// - In any power-down state all registers, memory and pins hold their values
// - Light idle ends on reset or any interrupt, even with interrupts masked
// - With the core mask flag clear, a waking interrupt fetches its vector
// - Deep idle stops the core; timers and tone run only on slow crystal
// - Stop instruction enters halt; only hardware reset wakes it, with warmup
// - Halt stops the core; timers and tone run only on slow crystal
// - Writing 1 to the detector bit enables it; result valid 3 us later
// - Detector bit is read twice; first read arms, second read gives result
// - Detector bit written is enable, read back is the low-voltage result
`ifndef PDL_DEFS_VH
`define PDL_DEFS_VH

`define PDL_ADDR_W        8
`define PDL_OFS_SYS       8'h30
`define PDL_OFS_STATUS    8'h34
`define PDL_OFS_MASK      8'h38

`define PDL_SYS_WSEL      3
`define PDL_SYS_DSEL      2
`define PDL_SYS_LVD       0
`define PDL_SYS_RESET     8'h00
`define PDL_IRQ_RESET     3'h0

`define PDL_EV_WAKE       0
`define PDL_EV_LOWV       1
`define PDL_EV_WARM       2

`define PDL_WARM_SHORT    9'h010
`define PDL_WARM_LONG     9'h100

`define PDL_CLK_NS        10
`define PDL_LVD_SETTLE_NS 3000
// Settle time in clock cycles, 3 us at a 10 ns clock
`define PDL_LVD_CYC       9'h12C

`define PDL_RESP_OKAY     2'h0
`define PDL_RESP_SLVERR   2'h2

`endif

// ---- pdl_warmup.v ----
// Oscillator warmup counter, counts synchronised oscillator cycles
`timescale 1ns/1ps
`include "pdl_defs.vh"
module pdl_warmup (
   input  wire aclk,
   input  wire aresetn,
   input  wire start,
   input  wire short_sel,
   input  wire osc_rise,
   output wire busy,
   output reg  done
);
   reg [8:0] cnt_q;

   assign busy = (cnt_q != 9'h000);

   // Reset itself starts a long warmup
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_q <= `PDL_WARM_LONG;
         done  <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
            cnt_q <= short_sel ? `PDL_WARM_SHORT : `PDL_WARM_LONG;
         else if (busy && osc_rise)
         begin
            cnt_q <= cnt_q - 9'h001;
            if (cnt_q == 9'h001)
               done <= 1'b1;
         end
      end
   end
endmodule

// ---- pdl_ctrl.v ----
// Power-down sequencer with low-voltage detector and AXI4-Lite registers
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pdl_defs.vh"
module pdl_ctrl (
   input  wire                    aclk,
   input  wire                    aresetn,
   input  wire [`PDL_ADDR_W-1:0]  s_axi_awaddr,
   input  wire                    s_axi_awvalid,
   output wire                    s_axi_awready,
   input  wire [31:0]             s_axi_wdata,
   input  wire [3:0]              s_axi_wstrb,
   input  wire                    s_axi_wvalid,
   output wire                    s_axi_wready,
   output wire [1:0]              s_axi_bresp,
   output wire                    s_axi_bvalid,
   input  wire                    s_axi_bready,
   input  wire [`PDL_ADDR_W-1:0]  s_axi_araddr,
   input  wire                    s_axi_arvalid,
   output wire                    s_axi_arready,
   output wire [31:0]             s_axi_rdata,
   output wire [1:0]              s_axi_rresp,
   output wire                    s_axi_rvalid,
   input  wire                    s_axi_rready,
   input  wire                    core_sleep,
   input  wire                    core_stop,
   input  wire                    core_irq_req,
   input  wire                    core_irq_disable,
   input  wire                    cpu_clock_source,
   input  wire                    periph_on_slow,
   input  wire                    osc_pin,
   input  wire                    lv_cmp_pin,
   output reg                     cpu_halt,
   output reg                     cpu_resume,
   output reg                     cpu_vector_fetch,
   output reg                     hold_state,
   output reg                     sysclk_en,
   output reg                     fast_osc_en,
   output reg                     timer_en,
   output reg                     tone_en,
   output wire                    lvd_enable,
   output wire [4:0]              power_state,
   output wire                    irq
);
   localparam [4:0] ST_RUN   = 5'h01;
   localparam [4:0] ST_LIGHT = 5'h02;
   localparam [4:0] ST_DEEP  = 5'h04;
   localparam [4:0] ST_HALT  = 5'h08;
   localparam [4:0] ST_WARM  = 5'h10;
   localparam [8:0] LVD_CYC  = `PDL_LVD_CYC;
   localparam [7:0] SYS_RST  = `PDL_SYS_RESET;

   reg  [4:0]  state_q;
   reg  [4:0]  state_d;
   reg         wsel_q;
   reg         dsel_q;
   reg         lvd_en_q;
   reg         lvd_armed_q;
   reg  [8:0]  settle_q;
   reg  [2:0]  status_q;
   reg  [2:0]  mask_q;
   reg  [1:0]  osc_sync_q;
   reg         osc_last_q;
   reg  [1:0]  lv_sync_q;
   reg         vec_q;
   reg         warm_start_q;
   reg         aw_hold_q;
   reg         w_hold_q;
   reg  [7:0]  awaddr_q;
   reg  [31:0] wdata_q;
   reg  [3:0]  wstrb_q;
   reg         bvalid_q;
   reg  [1:0]  bresp_q;
   reg         rvalid_q;
   reg  [31:0] rdata_q;
   reg  [1:0]  rresp_q;
   wire        warm_busy;
   wire        warm_done;
   wire        osc_rise;
   wire        wr_do;
   wire        rd_do;
   wire [1:0]  wr_sel;
   wire [1:0]  rd_sel;
   wire        settled;
   wire        lvd_bit;
   wire [7:0]  sys_rd;
   wire [2:0]  ev_set;
   wire        lowv_ev;
   wire        stopped;

   // Register select: 0 control, 1 status, 2 mask, 3 unmapped
   function [1:0] reg_sel;
      input [7:0] a;
      begin
         if (a == `PDL_OFS_SYS)
            reg_sel = 2'h0;
         else if (a == `PDL_OFS_STATUS)
            reg_sel = 2'h1;
         else if (a == `PDL_OFS_MASK)
            reg_sel = 2'h2;
         else
            reg_sel = 2'h3;
      end
   endfunction

   // Pin synchronisers
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         osc_sync_q <= 2'h0;
         osc_last_q <= 1'b0;
         lv_sync_q  <= 2'h0;
      end
      else
      begin
         osc_sync_q <= {osc_sync_q[0], osc_pin};
         osc_last_q <= osc_sync_q[1];
         lv_sync_q  <= {lv_sync_q[0], lv_cmp_pin};
      end
   end

   assign osc_rise = osc_sync_q[1] & ~osc_last_q;

   pdl_warmup u_warm (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .start     (warm_start_q),
      .short_sel (wsel_q),
      .osc_rise  (osc_rise),
      .busy      (warm_busy),
      .done      (warm_done)
   );

   // AXI4-Lite write channel
   assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
   assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign wr_do         = aw_hold_q & w_hold_q & ~bvalid_q;
   assign wr_sel        = reg_sel(awaddr_q);

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `PDL_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_do)
         begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= (wr_sel == 2'h3) ? `PDL_RESP_SLVERR : `PDL_RESP_OKAY;
         end
         else if (bvalid_q && s_axi_bready)
            bvalid_q <= 1'b0;
      end
   end

   // AXI4-Lite read channel
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign rd_do         = s_axi_arvalid & ~rvalid_q;
   assign rd_sel        = reg_sel(s_axi_araddr);

   // Detector result only after settling and an arming read
   assign settled = lvd_en_q & (settle_q == 9'h000);
   assign lvd_bit = settled & lvd_armed_q & lv_sync_q[1];
   assign sys_rd  = {4'h0, wsel_q, dsel_q, 1'b0, lvd_bit};
   assign lowv_ev = rd_do & (rd_sel == 2'h0) & lvd_bit;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `PDL_RESP_OKAY;
      end
      else if (rd_do)
      begin
         rvalid_q <= 1'b1;
         rresp_q  <= `PDL_RESP_OKAY;
         if (rd_sel == 2'h0)
            rdata_q <= {24'h00_0000, sys_rd};
         else if (rd_sel == 2'h1)
            rdata_q <= {29'h0, status_q};
         else if (rd_sel == 2'h2)
            rdata_q <= {29'h0, mask_q};
         else
         begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= `PDL_RESP_SLVERR;
         end
      end
      else if (rvalid_q && s_axi_rready)
         rvalid_q <= 1'b0;
   end

   // Control register and detector
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wsel_q      <= SYS_RST[`PDL_SYS_WSEL];
         dsel_q      <= SYS_RST[`PDL_SYS_DSEL];
         lvd_en_q    <= SYS_RST[`PDL_SYS_LVD];
         lvd_armed_q <= 1'b0;
         settle_q    <= 9'h000;
         mask_q      <= `PDL_IRQ_RESET;
      end
      else
      begin
         if (settle_q != 9'h000)
            settle_q <= settle_q - 9'h001;
         if (rd_do && rd_sel == 2'h0 && lvd_en_q)
            lvd_armed_q <= 1'b1;
         if (wr_do && wr_sel == 2'h0 && wstrb_q[0])
         begin
            wsel_q   <= wdata_q[`PDL_SYS_WSEL];
            dsel_q   <= wdata_q[`PDL_SYS_DSEL];
            lvd_en_q <= wdata_q[`PDL_SYS_LVD];
            if (!wdata_q[`PDL_SYS_LVD])
            begin
               lvd_armed_q <= 1'b0;
               settle_q    <= 9'h000;
            end
            else if (!lvd_en_q)
            begin
               lvd_armed_q <= 1'b0;
               settle_q    <= LVD_CYC;
            end
         end
         if (wr_do && wr_sel == 2'h2 && wstrb_q[0])
            mask_q <= wdata_q[2:0];
      end
   end

   assign lvd_enable = lvd_en_q;

   // Sticky status, cleared by reading it; a new event wins
   assign ev_set = {warm_done, lowv_ev, cpu_resume};

   always @(posedge aclk)
   begin
      if (!aresetn)
         status_q <= `PDL_IRQ_RESET;
      else if (rd_do && rd_sel == 2'h1)
         status_q <= ev_set;
      else
         status_q <= status_q | ev_set;
   end

   assign irq = |(status_q & mask_q);

   // Power state machine
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_RUN:
         begin
            if (core_stop)
               state_d = ST_HALT;
            else if (core_sleep)
               state_d = dsel_q ? ST_DEEP : ST_LIGHT;
         end
         ST_LIGHT:
         begin
            if (core_irq_req)
               state_d = ST_RUN;
         end
         ST_DEEP:
         begin
            if (core_irq_req)
               state_d = ST_WARM;
         end
         ST_HALT:
            state_d = ST_HALT;
         ST_WARM:
         begin
            if (!warm_busy && !warm_start_q)
               state_d = ST_RUN;
         end
         default:
            state_d = ST_RUN;
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q          <= ST_WARM;
         warm_start_q     <= 1'b0;
         vec_q            <= 1'b0;
         cpu_resume       <= 1'b0;
         cpu_vector_fetch <= 1'b0;
      end
      else
      begin
         state_q          <= state_d;
         warm_start_q     <= (state_q == ST_DEEP) && (state_d == ST_WARM);
         cpu_resume       <= 1'b0;
         cpu_vector_fetch <= 1'b0;
         if ((state_q == ST_LIGHT || state_q == ST_DEEP) && core_irq_req)
            vec_q <= ~core_irq_disable;
         if (state_q != ST_RUN && state_d == ST_RUN)
         begin
            cpu_resume       <= 1'b1;
            cpu_vector_fetch <= (state_q == ST_WARM) ? vec_q : ~core_irq_disable;
         end
      end
   end

   assign power_state = state_q;
   assign stopped     = (state_q == ST_DEEP) | (state_q == ST_HALT);

   // Clock and peripheral gating outputs
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cpu_halt    <= 1'b1;
         hold_state  <= 1'b1;
         sysclk_en   <= 1'b0;
         fast_osc_en <= 1'b1;
         timer_en    <= 1'b0;
         tone_en     <= 1'b0;
      end
      else
      begin
         cpu_halt    <= (state_d != ST_RUN);
         hold_state  <= (state_d != ST_RUN);
         sysclk_en   <= (state_d == ST_RUN) | (state_d == ST_LIGHT);
         fast_osc_en <= ~(((state_d == ST_DEEP) | (state_d == ST_HALT))
                          & ~cpu_clock_source);
         timer_en    <= (state_d == ST_RUN) | (state_d == ST_LIGHT)
                        | (((state_d == ST_DEEP) | (state_d == ST_HALT))
                           & periph_on_slow);
         tone_en     <= (state_d == ST_RUN) | (state_d == ST_LIGHT)
                        | (((state_d == ST_DEEP) | (state_d == ST_HALT))
                           & periph_on_slow);
      end
   end

   // Unused control bits above the stored fields
   wire unused_ok = stopped & (|wdata_q[31:8]) & (|wstrb_q[3:1]);
endmodule

// ---- pdl_core_model.sv ----
// Behavioural processor core that issues sleep and stop instructions
`timescale 1ns/1ps
module pdl_core_model (
   input  wire aclk,
   input  wire aresetn,
   input  wire go_sleep,
   input  wire go_stop,
   input  wire wake,
   input  wire irq_dis,
   input  wire cpu_halt,
   input  wire cpu_resume,
   output reg  core_sleep,
   output reg  core_stop,
   output reg  core_irq_req,
   output wire core_irq_disable
);
   assign core_irq_disable = irq_dis;
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         core_sleep <= 1'h0;
         core_stop <= 1'h0;
         core_irq_req <= 1'h0;
      end
      else
      begin
         // Instructions only execute while the core runs
         core_sleep <= go_sleep & !cpu_halt;
         core_stop <= go_stop & !cpu_halt;
         // Request dropped once the core has resumed
         if (cpu_resume)
            core_irq_req <= 1'h0;
         else if (wake)
            core_irq_req <= 1'h1;
      end
   end
endmodule

// ---- pdl_ctrl_assertions.sv ----
// Port-level assertions for the power-down controller
`timescale 1ns/1ps
module pdl_chk (
   input wire       aclk,
   input wire       aresetn,
   input wire       core_sleep,
   input wire       core_stop,
   input wire       core_irq_req,
   input wire       core_irq_disable,
   input wire       cpu_clock_source,
   input wire       periph_on_slow,
   input wire       cpu_halt,
   input wire       cpu_resume,
   input wire       cpu_vector_fetch,
   input wire       hold_state,
   input wire       sysclk_en,
   input wire       fast_osc_en,
   input wire       timer_en,
   input wire       tone_en,
   input wire [4:0] power_state
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reg deep_woke_q;

   // Marks a warmup entered from deep idle rather than from reset
   always @(posedge aclk)
   begin
      if (!aresetn)
         deep_woke_q <= 1'b0;
      else if (power_state == 5'h04)
         deep_woke_q <= 1'b1;
      else if (power_state == 5'h01)
         deep_woke_q <= 1'b0;
   end

   sequence s_deep_wake;
      power_state == 5'h04 && core_irq_req;
   endsequence
   sequence s_parked;
      power_state inside {5'h04, 5'h08} && $stable(power_state) && $stable(cpu_clock_source)
         && $stable(periph_on_slow);
   endsequence
   a_sleep_enter: assert property (
      power_state == 5'h01 && core_sleep && !core_stop |=> power_state inside {5'h02, 5'h04})
      else $error("sleep did not enter an idle state");
   a_stop_enter: assert property (
      power_state == 5'h01 && core_stop |=> power_state == 5'h08)
      else $error("stop did not enter halt");
   a_halt_sticky: assert property (
      power_state == 5'h08 |=> power_state == 5'h08)
      else $error("halt left without reset");
   a_light_wake: assert property (
      power_state == 5'h02 && core_irq_req |=> power_state == 5'h01 && cpu_resume)
      else $error("light idle did not wake");
   a_deep_warm: assert property (
      s_deep_wake |=> power_state == 5'h10 ##1 power_state == 5'h10)
      else $error("deep wake skipped warmup");
   a_vector_pair: assert property (
      cpu_resume || cpu_vector_fetch |-> cpu_resume
         && cpu_vector_fetch == (($past(power_state) != 5'h10 || deep_woke_q)
                                 && !$past(core_irq_disable)))
      else $error("vector fetch wrong on resume");
   a_halt_freeze: assert property (
      cpu_halt == (power_state != 5'h01) && hold_state == cpu_halt)
      else $error("freeze does not follow state");
   a_parked_gates: assert property (
      s_parked |-> !sysclk_en && fast_osc_en == cpu_clock_source && timer_en == periph_on_slow
         && tone_en == periph_on_slow)
      else $error("clock gating wrong while parked");
   a_light_runs: assert property (
      power_state == 5'h02 && $past(power_state) == 5'h02 |-> sysclk_en && fast_osc_en
         && timer_en && tone_en)
      else $error("light idle stopped a clock");
endmodule

// ---- tb_power_down_and_lowvolt_ctrl.sv ----
// Self-checking bench for the power-down and low-voltage controller
`timescale 1ns/1ps
`include "pdl_defs.vh"
module tb_power_down_and_lowvolt_ctrl;
   reg         aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   reg         arvalid = 1'h0, rready = 1'h0, go_sleep = 1'h0, go_stop = 1'h0, wake = 1'h0;
   reg         irq_dis = 1'h0, clk_src = 1'h0, per_slow = 1'h0, osc_pin = 1'h0, lv_cmp = 1'h0;
   reg         vf_q = 1'h0;
   reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
   reg  [31:0] wdata = 32'h0, seed = 32'h4728DFA9, rd_q;
   reg  [2:0]  osc_div = 3'h0;
   reg  [1:0]  rr_q;
   wire        awready, wready, bvalid, arready, rvalid, c_sleep, c_stop, c_irq, c_dis;
   wire        cpu_halt, cpu_resume, vfetch, hold_state, sysclk_en, fast_osc_en, timer_en;
   wire        tone_en, lvd_enable, irq;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [4:0]  power_state;
   integer     failures = 0, num_checks = 0, r, i, m_ctrl;

   always #5 aclk = ~aclk;
   always @(posedge aclk)
   begin
      osc_div <= osc_div + 3'h1;
      osc_pin <= osc_div[2];
      if (cpu_resume)
         vf_q <= vfetch;
      // Primed with the wrong value at each sleep
      else if (go_sleep)
         vf_q <= irq_dis;
   end

   pdl_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .core_sleep(c_sleep), .core_stop(c_stop), .core_irq_req(c_irq), .core_irq_disable(c_dis),
      .cpu_clock_source(clk_src), .periph_on_slow(per_slow), .osc_pin(osc_pin),
      .lv_cmp_pin(lv_cmp), .cpu_halt(cpu_halt), .cpu_resume(cpu_resume),
      .cpu_vector_fetch(vfetch), .hold_state(hold_state), .sysclk_en(sysclk_en),
      .fast_osc_en(fast_osc_en), .timer_en(timer_en), .tone_en(tone_en),
      .lvd_enable(lvd_enable), .power_state(power_state), .irq(irq));

   pdl_core_model u_core (.aclk(aclk), .aresetn(aresetn), .go_sleep(go_sleep), .go_stop(go_stop),
      .wake(wake), .irq_dis(irq_dis), .cpu_halt(cpu_halt), .cpu_resume(cpu_resume),
      .core_sleep(c_sleep), .core_stop(c_stop), .core_irq_req(c_irq), .core_irq_disable(c_dis));

   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task wrap_up;
   begin
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask

   task chk(input [31:0] seen, input [31:0] exp);
   begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask

   task hung;
   begin
      failures = failures + 1;
      wrap_up;
   end
   endtask

   task wr(input [7:0] a, input [31:0] d, input [1:0] er);
      integer n;
      reg     dn;
   begin
      dn = 1'h0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 50 && !dn; n = n + 1)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
         if (bvalid)
         begin
            dn = 1'h1;
            chk(bresp, er);
         end
      end
      if (!dn)
         hung;
   end
   endtask

   task rd(input [7:0] a);
      integer n;
      reg     dn;
   begin
      dn = 1'h0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 50 && !dn; n = n + 1)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'h0;
         if (rvalid)
         begin
            dn = 1'h1;
            rd_q = rdata;
            rr_q = rresp;
         end
      end
      if (!dn)
         hung;
   end
   endtask

   // Waits for a state, counting oscillator rises on the way
   task wait_ps(input [4:0] s);
      integer n;
      reg     p;
   begin
      r = 0;
      p = osc_pin;
      for (n = 0; n < 4000 && power_state !== s; n = n + 1)
      begin
         @(posedge aclk);
         r = r + (osc_pin && !p);
         p = osc_pin;
      end
      if (n == 4000)
         hung;
   end
   endtask

   task pulse(input integer k);
   begin
      go_sleep <= k == 0;
      go_stop <= k == 1;
      wake <= k == 2;
      @(posedge aclk);
      go_sleep <= 1'h0;
      go_stop <= 1'h0;
      wake <= 1'h0;
      repeat (3) @(posedge aclk);
   end
   endtask

   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      wait_ps(5'h10);
      wait_ps(5'h01);
      chk(r >= 255 && r <= 258, 1);
      rd(`PDL_OFS_SYS);
      chk(rd_q, `PDL_SYS_RESET);
      rd(8'h3C);
      chk({rr_q, rd_q[29:0]}, {`PDL_RESP_SLVERR, 30'h0});
      wr(8'h3C, 32'hFF, `PDL_RESP_SLVERR);
      for (i = 0; i < 4; i = i + 1)
      begin
         seed = lfsr(seed);
         clk_src <= seed[0];
         per_slow <= seed[1];
         irq_dis <= i[0];
         m_ctrl = i[1] ? ({i[0], 3'h0} | 32'h4) : 32'h0;
         wr(`PDL_OFS_SYS, m_ctrl, `PDL_RESP_OKAY);
         pulse(0);
         chk(power_state, i[1] ? 5'h04 : 5'h02);
         if (i[1])
            chk({sysclk_en, fast_osc_en, timer_en}, {1'h0, clk_src, per_slow});
         else
            chk({sysclk_en, timer_en, tone_en}, 3'h7);
         pulse(2);
         wait_ps(5'h01);
         if (i[1])
            chk(r >= (i[0] ? 14 : 254) && r <= (i[0] ? 18 : 258), 1);
         repeat (2) @(posedge aclk);
         chk(vf_q, !i[0]);
      end
      wr(`PDL_OFS_MASK, 32'h1, `PDL_RESP_OKAY);
      chk(irq, 1'h1);
      rd(`PDL_OFS_STATUS);
      chk(rd_q, 32'h5);
      @(posedge aclk);
      chk(irq, 1'h0);
      lv_cmp <= 1'h1;
      wr(`PDL_OFS_SYS, 32'h1, `PDL_RESP_OKAY);
      chk(lvd_enable, 1'h1);
      rd(`PDL_OFS_SYS);
      chk(rd_q, 32'h0);
      repeat (310) @(posedge aclk);
      rd(`PDL_OFS_SYS);
      chk(rd_q, 32'h1);
      lv_cmp <= 1'h0;
      repeat (10) @(posedge aclk);
      rd(`PDL_OFS_SYS);
      chk(rd_q, 32'h0);
      wr(`PDL_OFS_SYS, 32'h0, `PDL_RESP_OKAY);
      chk(lvd_enable, 1'h0);
      pulse(1);
      chk({power_state, cpu_halt}, {5'h08, 1'h1});
      pulse(2);
      repeat (20) @(posedge aclk);
      chk(power_state, 5'h08);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      wait_ps(5'h10);
      wait_ps(5'h01);
      chk(r >= 255 && r <= 258, 1);
      wrap_up;
   end
endmodule

bind pdl_ctrl pdl_chk u_chk (.aclk(aclk), .aresetn(aresetn), .core_sleep(core_sleep),
   .core_stop(core_stop), .core_irq_req(core_irq_req), .core_irq_disable(core_irq_disable),
   .cpu_clock_source(cpu_clock_source), .periph_on_slow(periph_on_slow), .cpu_halt(cpu_halt),
   .cpu_resume(cpu_resume), .cpu_vector_fetch(cpu_vector_fetch), .hold_state(hold_state),
   .sysclk_en(sysclk_en), .fast_osc_en(fast_osc_en), .timer_en(timer_en), .tone_en(tone_en),
   .power_state(power_state));
